// ==== sgpc_port.sv ====
// Purpose: serial slave that configures, drives and reads back the pin port
// Assumes: serial clock well below clk/4; DIN taken on SCLK falling edge,
//          DOUT changed on SCLK rising edge
// Notes:   WIDE_PORT=1 is the 12-pin variant, 0 the 4-pin variant
//
// Summary of operation
// - Command byte with upper six bits zero selects port; low two bits pick operation.
// - Command 00000011 loads next 8 or 16 bits into pin configuration.
// - Shifted configuration or write data applied only at chip select rising edge.
// - After reset every pin is an input.
// - Command 00000010 loads next 8 or 16 bits into pin output levels.
// - Command 00000001 shifts pin states out over following 8 or 16 clocks.
// - Read returns pin states sampled at the moment of the read.
// - 4-pin write byte order: C1, C0, A1, A0, then four ignored bits; read sends four zero bits, then C1, C0, A1, A0.
// - Config,write: 11 high, 10 low, 01 input, 00 open-drain pulldown.

`timescale 1ns/1ps

module sgpc_port #(
  parameter bit WIDE_PORT = 1'b1
) (
  input  wire logic                     clk,
  input  wire logic                     rstn,
  input  wire logic                     csN,
  input  wire logic                     sclk,
  input  wire logic                     din,
  output logic                          dout,
  input  wire logic [11:0]              gpioIn,
  output sgpc_pkg::sgpc_pin_drive_s     pinDrive
);

  // ==========================================================================
  // input synchronisers
  sgpc_pkg::sgpc_serial_s serRaw;
  sgpc_pkg::sgpc_serial_s serSync;
  logic [11:0]            pinSync;

  assign serRaw = '{csN: csN, sclk: sclk, din: din};

  // reset to the idle levels so no false select edge follows reset
  sgpc_sync2 #(.WIDTH(3), .RESET_VALUE(sgpc_pkg::SERIAL_IDLE)) u_serSync (
    .clk     (clk),
    .rstn    (rstn),
    .asyncIn (serRaw),
    .syncOut (serSync)
  );

  sgpc_sync2 #(.WIDTH(12)) u_pinSync (
    .clk     (clk),
    .rstn    (rstn),
    .asyncIn (gpioIn),
    .syncOut (pinSync)
  );

  // ==========================================================================
  // edge detection on synchronised serial lines
  logic sclkPrev_ff;
  logic csPrev_ff;
  logic sclkRise;
  logic sclkFall;
  logic csRise;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sclkPrev_ff <= 1'b0;
      csPrev_ff   <= 1'b1;
    end else begin
      sclkPrev_ff <= serSync.sclk;
      csPrev_ff   <= serSync.csN;
    end
  end

  assign sclkRise = serSync.sclk & ~sclkPrev_ff;
  assign sclkFall = ~serSync.sclk & sclkPrev_ff;
  assign csRise   = serSync.csN & ~csPrev_ff;

  // ==========================================================================
  // word size and packing helpers
  logic [4:0] wordBits;
  assign wordBits = WIDE_PORT ? sgpc_pkg::WORD_BITS_12 : sgpc_pkg::WORD_BITS_4;

  // map a shifted data word onto the pin vector; unused pins keep fill
  function automatic logic [11:0] unpackWord(input logic [15:0] word, input logic [11:0] fill);
    logic [11:0] v;
    v = fill;
    if (WIDE_PORT) begin
      v = word[sgpc_pkg::WIDE_LSB +: 12];
    end else begin
      v[sgpc_pkg::PIN_C1] = word[sgpc_pkg::NARROW_LSB + 3];
      v[sgpc_pkg::PIN_C0] = word[sgpc_pkg::NARROW_LSB + 2];
      v[sgpc_pkg::PIN_A1] = word[sgpc_pkg::NARROW_LSB + 1];
      v[sgpc_pkg::PIN_A0] = word[sgpc_pkg::NARROW_LSB];
    end
    return v;
  endfunction

  // read word, pins placed from bit 11 down so the first four bits out (bits 15 to 12) are always zero
  function automatic logic [15:0] packRead(input logic [11:0] pins);
    logic [15:0] w;
    w = 16'h0000;
    if (WIDE_PORT) begin
      w[11:0] = pins;
    end else begin
      w[11:8] = {pins[sgpc_pkg::PIN_C1], pins[sgpc_pkg::PIN_C0],
                 pins[sgpc_pkg::PIN_A1], pins[sgpc_pkg::PIN_A0]};
    end
    return w;
  endfunction

  // ==========================================================================
  // serial protocol state
  sgpc_pkg::sgpc_state_e state_ff,  nxt_state;
  logic [4:0]            bitCnt_ff, nxt_bitCnt;
  logic [15:0]           shift_ff,  nxt_shift;
  logic [1:0]            op_ff,     nxt_op;
  logic [15:0]           rdShift_ff, nxt_rdShift;
  logic                  dout_ff,   nxt_dout;
  logic [11:0]           cfg_ff,    nxt_cfg;
  logic [11:0]           wr_ff,     nxt_wr;
  logic [7:0]            cmdByte;
  logic [11:0]           newWord;
  logic [11:0]           newLevel;
  logic                  commit;

  assign cmdByte  = {shift_ff[6:0], serSync.din};
  assign newWord  = unpackWord(shift_ff, sgpc_pkg::CONFIG_RESET);
  assign newLevel = unpackWord(shift_ff, sgpc_pkg::LEVEL_RESET);
  assign commit   = csRise && (state_ff == sgpc_pkg::ST_DATA_IN) && (bitCnt_ff == wordBits);

  always_comb begin
    nxt_state   = state_ff;
    nxt_bitCnt  = bitCnt_ff;
    nxt_shift   = shift_ff;
    nxt_op      = op_ff;
    nxt_rdShift = rdShift_ff;
    nxt_dout    = dout_ff;
    nxt_cfg     = cfg_ff;
    nxt_wr      = wr_ff;
    if (serSync.csN) begin
      nxt_state  = sgpc_pkg::ST_IDLE;
      nxt_bitCnt = 5'h00;
      nxt_dout   = 1'b0;
      if (commit && op_ff == sgpc_pkg::OP_CONFIG) begin
        nxt_cfg = newWord;
      end
      if (commit && op_ff == sgpc_pkg::OP_WRITE) begin
        nxt_wr = newLevel;
      end
    end else begin
      case (state_ff)
        sgpc_pkg::ST_IDLE: begin
          nxt_state  = sgpc_pkg::ST_CMD;
          nxt_bitCnt = 5'h00;
        end
        sgpc_pkg::ST_CMD: begin
          if (sclkFall) begin
            nxt_shift  = {shift_ff[14:0], serSync.din};
            nxt_bitCnt = bitCnt_ff + 5'h01;
            if (bitCnt_ff == sgpc_pkg::CMD_LAST_BIT) begin
              nxt_bitCnt = 5'h00;
              nxt_op     = cmdByte[1:0];
              if (cmdByte[7:2] != sgpc_pkg::CMD_SEL_VALUE || cmdByte[1:0] == 2'h0) begin
                nxt_state = sgpc_pkg::ST_IGNORE;
              end else if (cmdByte[1:0] == sgpc_pkg::OP_READ) begin
                nxt_state   = sgpc_pkg::ST_DATA_OUT;
                nxt_rdShift = packRead(pinSync);
              end else begin
                nxt_state = sgpc_pkg::ST_DATA_IN;
              end
            end
          end
        end
        sgpc_pkg::ST_DATA_IN: begin
          if (sclkFall && bitCnt_ff < wordBits) begin
            nxt_shift  = {shift_ff[14:0], serSync.din};
            nxt_bitCnt = bitCnt_ff + 5'h01;
          end
        end
        sgpc_pkg::ST_DATA_OUT: begin
          if (sclkRise) begin
            if (bitCnt_ff < wordBits) begin
              nxt_dout    = rdShift_ff[15];
              nxt_rdShift = {rdShift_ff[14:0], 1'b0};
              nxt_bitCnt  = bitCnt_ff + 5'h01;
            end else begin
              nxt_dout = 1'b0;
            end
          end
        end
        sgpc_pkg::ST_IGNORE: begin
          nxt_dout = 1'b0;
        end
        default: begin
          nxt_state = sgpc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_ff   <= sgpc_pkg::ST_IDLE;
      bitCnt_ff  <= 5'h00;
      shift_ff   <= 16'h0000;
      op_ff      <= 2'h0;
      rdShift_ff <= 16'h0000;
      dout_ff    <= 1'b0;
      cfg_ff     <= sgpc_pkg::CONFIG_RESET;
      wr_ff      <= sgpc_pkg::LEVEL_RESET;
    end else begin
      state_ff   <= nxt_state;
      bitCnt_ff  <= nxt_bitCnt;
      shift_ff   <= nxt_shift;
      op_ff      <= nxt_op;
      rdShift_ff <= nxt_rdShift;
      dout_ff    <= nxt_dout;
      cfg_ff     <= nxt_cfg;
      wr_ff      <= nxt_wr;
    end
  end

  // ==========================================================================
  // pin drivers
  sgpc_pkg::sgpc_pin_drive_s pins_ff, nxt_pins;

  always_comb begin
    nxt_pins.level = cfg_ff & wr_ff;
    nxt_pins.oeN   = ~cfg_ff & wr_ff;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pins_ff.level <= sgpc_pkg::LEVEL_RESET;
      pins_ff.oeN   <= sgpc_pkg::OE_N_RESET;
    end else begin
      pins_ff <= nxt_pins;
    end
  end

  assign pinDrive = pins_ff;
  assign dout     = dout_ff;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_CMD_SELECT: assert property (
    (state_ff == sgpc_pkg::ST_CMD && sclkFall && bitCnt_ff == sgpc_pkg::CMD_LAST_BIT
     && cmdByte[7:2] != sgpc_pkg::CMD_SEL_VALUE) |=> state_ff == sgpc_pkg::ST_IGNORE
  ) else $error("foreign command byte not ignored");

  AST_CONFIG_LOAD: assert property (
    (commit && op_ff == sgpc_pkg::OP_CONFIG) |=> cfg_ff == $past(newWord)
  ) else $error("configuration word not loaded");

  AST_APPLY_AT_CS_RISE: assert property (
    ($changed(cfg_ff) || $changed(wr_ff)) |-> $past(csRise)
  ) else $error("pin registers changed outside select rising edge");

  AST_POWERUP_INPUT: assert property (
    $rose(rstn) |-> (pins_ff.oeN == sgpc_pkg::OE_N_RESET) ##1 (pins_ff.oeN == sgpc_pkg::OE_N_RESET)
  ) else $error("pins not inputs after reset");

  AST_WRITE_LOAD: assert property (
    (commit && op_ff == sgpc_pkg::OP_WRITE) |=> wr_ff == $past(newLevel) && cfg_ff == $past(cfg_ff)
  ) else $error("write word not loaded");

  AST_READ_QUIET: assert property (
    (state_ff != sgpc_pkg::ST_DATA_OUT) |-> !dout_ff
  ) else $error("data out active outside read");

  AST_READ_BIT: assert property (
    (state_ff == sgpc_pkg::ST_DATA_OUT && sclkRise && bitCnt_ff < wordBits)
    |=> dout_ff == $past(rdShift_ff[15]) && bitCnt_ff == $past(bitCnt_ff) + 5'h01
  ) else $error("read bit order wrong");

  AST_NARROW_UNUSED: assert property (
    !WIDE_PORT |-> (cfg_ff & 12'hCFC) == 12'h000 && (wr_ff & 12'hCFC) == 12'hCFC
  ) else $error("unused pin touched in 4-pin variant");

  AST_PIN_MODE: assert property (
    ($changed(cfg_ff) || $changed(wr_ff)) |=> pins_ff.oeN == (~$past(cfg_ff) & $past(wr_ff))
                         && pins_ff.level == ($past(cfg_ff) & $past(wr_ff))
  ) else $error("pin mode does not follow config and write bits");

  AST_CMD_MSB_FIRST: assert property (
    (state_ff == sgpc_pkg::ST_CMD && sclkFall) |=> shift_ff[0] == $past(serSync.din)
  ) else $error("command bit not shifted in");

  AST_SHORT_DROPPED: assert property (
    (csRise && state_ff == sgpc_pkg::ST_DATA_IN && bitCnt_ff != wordBits)
    |=> $stable(cfg_ff) && $stable(wr_ff)
  ) else $error("incomplete data word applied");

  AST_IGNORE_QUIET: assert property (
    (state_ff == sgpc_pkg::ST_IGNORE) |=> $stable(cfg_ff) && $stable(wr_ff) && !dout_ff
  ) else $error("ignored frame changed port state");

  AST_CMD_COUNT: assert property (
    (state_ff == sgpc_pkg::ST_CMD && !serSync.csN && sclkFall && bitCnt_ff != sgpc_pkg::CMD_LAST_BIT)
    |=> state_ff == sgpc_pkg::ST_CMD && bitCnt_ff == $past(bitCnt_ff) + 5'h01
  ) else $error("command bit count wrong");

  COV_CONFIG: cover property (commit && op_ff == sgpc_pkg::OP_CONFIG);
  COV_WRITE:  cover property (commit && op_ff == sgpc_pkg::OP_WRITE);
  COV_READ:   cover property (state_ff == sgpc_pkg::ST_DATA_OUT && bitCnt_ff == wordBits);
  COV_IGNORE: cover property (state_ff == sgpc_pkg::ST_IGNORE);
  COV_SHORT:  cover property (csRise && state_ff == sgpc_pkg::ST_DATA_IN && bitCnt_ff != wordBits);

endmodule // sgpc_port

// ==== sgpc_pkg.sv ====
// Purpose: shared constants and types for the serial-controlled pin port
// Assumes: serial pins are sampled by the system clock
// Notes:   pin vector order is {group C, group B, group A}, pin 0 lowest

package sgpc_pkg;

  // ==========================================================================
  // command byte
  localparam int          CMD_BITS      = 8;
  localparam logic [5:0]  CMD_SEL_VALUE = 6'h00;
  localparam logic [1:0]  OP_CONFIG     = 2'h3;
  localparam logic [1:0]  OP_WRITE      = 2'h2;
  localparam logic [1:0]  OP_READ       = 2'h1;

  // ==========================================================================
  // data word sizes and pin layout
  localparam int          PIN_COUNT     = 12;
  localparam logic [4:0]  WORD_BITS_12  = 5'h10;
  localparam logic [4:0]  WORD_BITS_4   = 5'h08;
  localparam logic [4:0]  CMD_LAST_BIT  = 5'h07;
  localparam int          WIDE_LSB      = 4;
  localparam int          NARROW_LSB    = 4;
  localparam int          PIN_C1        = 9;
  localparam int          PIN_C0        = 8;
  localparam int          PIN_A1        = 1;
  localparam int          PIN_A0        = 0;

  // ==========================================================================
  // values after reset: every pin an input (config 0, write 1)
  localparam logic [11:0] CONFIG_RESET  = 12'h000;
  localparam logic [11:0] LEVEL_RESET   = 12'hFFF;
  localparam logic [11:0] OE_N_RESET    = 12'hFFF;
  // serial lines at rest {csN, sclk, din}: select high, clock low
  localparam logic [2:0]  SERIAL_IDLE   = 3'h4;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD,
    ST_DATA_IN,
    ST_DATA_OUT,
    ST_IGNORE
  } sgpc_state_e;

  typedef struct packed {
    logic csN;
    logic sclk;
    logic din;
  } sgpc_serial_s;

  typedef struct packed {
    logic [11:0] level;
    logic [11:0] oeN;
  } sgpc_pin_drive_s;

endpackage

// ==== sgpc_sync2.sv ====
// Purpose: two-flop synchroniser for asynchronous inputs
// Assumes: inputs are quasi-static relative to clk
// Notes:   first stage feeds only the second stage

`timescale 1ns/1ps

module sgpc_sync2 #(
  parameter int               WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      stage1_ff <= RESET_VALUE;
      stage2_ff <= RESET_VALUE;
    end else begin
      stage1_ff <= asyncIn;
      stage2_ff <= stage1_ff;
    end
  end

  assign syncOut = stage2_ff;

endmodule // sgpc_sync2

// ==== sgpc_host_model.sv ====
// Purpose: serial host that frames commands and data for the pin port
// Assumes: each serial clock phase lasts HALF system clocks
// Notes:   serial clock idles low between frames; din shows no stale bit

`timescale 1ns/1ps

module sgpc_host_model #(
  parameter int HALF = 6
) (
  input  wire logic clk,
  output logic      csN,
  output logic      sclk,
  output logic      din,
  input  wire logic dout
);
  initial begin
    csN  = 1'b1;
    sclk = 1'b0;
    din  = 1'b0;
  end

  task automatic wclk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // ==========================================================================
  // one frame: command byte, then nd data bits msb first
  task automatic frame(input logic [7:0] cmd, input logic [15:0] data, input int nd, input bit hold,
                       output logic [15:0] rd);
    logic [23:0] word;
    word = {cmd, data};
    rd   = 16'h0000;
    wclk(1);
    csN = 1'b0;
    wclk(HALF);
    for (int i = 0; i < 8 + nd; i++) begin
      din  = word[23 - i];
      sclk = 1'b1;
      wclk(HALF);
      if (i >= 8) rd = {rd[14:0], dout};
      sclk = 1'b0;
      wclk(HALF);
    end
    if (!hold) finish_frame();
  endtask

  task automatic finish_frame();
    csN = 1'b1;
    din = ~din;
    wclk(8);
  endtask
endmodule // sgpc_host_model

// ==== tb_top.sv ====
// Purpose: self-checking bench for both pin port variants
// Assumes: host model frames all serial traffic
// Notes:   drive compared raw at reset, elsewhere on oeN and on level where driven only

`timescale 1ns/1ps

module tb_top;
  logic                      clk;
  logic                      rstn;
  logic [11:0]               gpioIn;
  logic                      csNWide, sclkWide, dinWide, doutWide;
  logic                      csNNar, sclkNar, dinNar, doutNar;
  sgpc_pkg::sgpc_pin_drive_s driveWide, driveNar;
  logic [15:0]               rd;
  int                        nFail, nChecks, cycles;

  initial clk = 1'b0;
  always #4 clk = ~clk;

  sgpc_port #(.WIDE_PORT(1'b1)) dut (.clk(clk), .rstn(rstn), .csN(csNWide), .sclk(sclkWide),
    .din(dinWide), .dout(doutWide), .gpioIn(gpioIn), .pinDrive(driveWide));
  sgpc_port #(.WIDE_PORT(1'b0)) dutNar (.clk(clk), .rstn(rstn), .csN(csNNar), .sclk(sclkNar),
    .din(dinNar), .dout(doutNar), .gpioIn(gpioIn), .pinDrive(driveNar));
  sgpc_host_model hostWide (.clk(clk), .csN(csNWide), .sclk(sclkWide), .din(dinWide), .dout(doutWide));
  sgpc_host_model hostNar (.clk(clk), .csN(csNNar), .sclk(sclkNar), .din(dinNar), .dout(doutNar));

  // ==========================================================================
  // helpers
  function automatic logic [23:0] expDrive(input logic [11:0] cfg, input logic [11:0] wr);
    return {cfg & wr, ~cfg & wr};
  endfunction

  function automatic logic [23:0] seen(input sgpc_pkg::sgpc_pin_drive_s d);
    return {d.level & ~d.oeN, d.oeN};
  endfunction

  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    nChecks++;
    if (got !== exp) begin
      nFail++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic endSim();
    if (nFail == 0 && nChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset();
    check("wide drive", 24'hFF_FFFF, driveWide);
    check("narrow drive", 24'hFF_FFFF, driveNar);
    check("dout", 24'h00_0000, {22'h0, doutWide, doutNar});
  endtask

  task automatic t_wide_ops();
    hostWide.frame(8'h02, 16'hA5C0, 16, 1'b1, rd);
    check("drive before commit", expDrive(12'h000, 12'hFFF), seen(driveWide));
    hostWide.finish_frame();
    check("drive after write", expDrive(12'h000, 12'hA5C), seen(driveWide));
    hostWide.frame(8'h03, 16'h3C60, 16, 1'b0, rd);
    check("drive after config", expDrive(12'h3C6, 12'hA5C), seen(driveWide));
  endtask

  task automatic t_refused();
    hostWide.frame(8'h43, 16'h0000, 16, 1'b0, rd);
    hostWide.frame(8'h00, 16'h0000, 16, 1'b0, rd);
    hostWide.frame(8'h03, 16'hFFF0, 10, 1'b0, rd);
    check("drive after refused", expDrive(12'h3C6, 12'hA5C), seen(driveWide));
    gpioIn = 12'hFFF;
    hostWide.frame(8'h41, 16'h0000, 16, 1'b0, rd);
    check("refused read", 24'h00_0000, {8'h00, rd});
  endtask

  task automatic t_read();
    gpioIn = 12'h9A5;
    hostWide.frame(8'h01, 16'h0000, 16, 1'b0, rd);
    check("wide read", 24'h00_09A5, {8'h00, rd});
    gpioIn = 12'h35A;
    hostWide.frame(8'h01, 16'h0000, 16, 1'b0, rd);
    check("wide reread", 24'h00_035A, {8'h00, rd});
  endtask

  task automatic t_narrow();
    hostNar.frame(8'h02, 16'hB000, 8, 1'b0, rd);
    hostNar.frame(8'h03, 16'hF000, 8, 1'b0, rd);
    check("narrow drive", expDrive(12'h303, 12'hEFF), seen(driveNar));
    gpioIn = 12'h9A5;
    hostNar.frame(8'h01, 16'h0000, 8, 1'b0, rd);
    check("narrow read", 24'h00_0005, {8'h00, rd});
  endtask

  task automatic t_rereset();
    rstn = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    check("wide drive after reset", 24'hFF_FFFF, driveWide);
    check("narrow drive after reset", 24'hFF_FFFF, driveNar);
    rstn = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    hostWide.frame(8'h02, 16'h0000, 16, 1'b0, rd);
    check("write after reset", expDrive(12'h000, 12'h000), seen(driveWide));
  endtask

  // ==========================================================================
  // run control
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      nFail++;
      endSim();
    end
  end

  initial begin
    nFail   = 0;
    nChecks = 0;
    cycles  = 0;
    rstn    = 1'b0;
    gpioIn  = 12'h000;
    repeat (8) @(posedge clk);
    #1;
    t_reset();
    rstn = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    t_wide_ops();
    t_refused();
    t_read();
    t_narrow();
    t_rereset();
    endSim();
  end
endmodule // tb_top
